/* File: verilog/gpff_pkg.sv */
// Shared types and constants for the general-purpose flip-flop block
package gpff_pkg;

    // Pin inputs from the surrounding logic, grouped as one vector
    typedef struct packed {
        logic rs_set_n;    // Unclocked latch set, active low
        logic rs_reset_n;  // Unclocked latch reset, active low
        logic cl_set;      // Clocked latch set, active high
        logic cl_reset;    // Clocked latch reset, active high
        logic cl_clk;      // Clocked latch enable pulse
        logic d_data;      // Data flip-flop input
        logic d_clk;       // Data flip-flop clock
        logic d_set_n;     // Data flip-flop direct set, active low
        logic d_reset_n;   // Data flip-flop direct reset, active low
        logic jk_j;        // J input
        logic jk_k;        // K input
        logic jk_clk;      // J-K clock, idle low
        logic jk_set_n;    // J-K direct set, active low
        logic jk_reset_n;  // J-K direct reset, active low
    } gpff_pins_t;

    // Stored state of all four elements, seen as the one outputs
    typedef struct packed {
        logic rs_one;      // Unclocked latch one output
        logic cl_one;      // Clocked latch one output
        logic d_one;       // Data flip-flop one output
        logic jk_one;      // J-K slave, one output
    } gpff_state_t;

    localparam int          GPFF_NPINS     = $bits(gpff_pins_t);
    // Idle pin levels: active-low inputs high, everything else low
    localparam gpff_pins_t  GPFF_PINS_IDLE = 14'h3063;
    localparam gpff_state_t GPFF_STATE_RST = 4'h0;
    localparam logic        GPFF_BIT_RST   = 1'b0;

endpackage

/* File: verilog/gpff_top.sv */
// General-purpose latches and flip-flops sampled by the system clock
// Function
// - Unclocked latch, both inputs low: the input released last sets final state.
// - Clocked latch holds while its clock is low; set/reset only during pulse.
// - Data flip-flop loads its data input on the clock's rising edge.
// - Data input ignored after the rising edge until the clock falls.
// - Internal set is data, internal reset its inverse; never both active.
// - Data flip-flop has direct set and reset that act regardless of clock.
// - Direct set and reset are active low, acting for as long as the pin is held low.
// - J-K master loads from J and K as clock rises; slave unchanged while high.
// - J-K master copies into slave and outputs on the clock's falling edge.
// - Neither J nor K: J-K output keeps its previous state.
// - Both J and K: J-K output inverts at the falling edge.
// - Only J gives one, only K gives zero, at the falling edge.
// - While clock is high the slave steering blocks the master path; only direct set and reset reach the slave.
module gpff_top
    import gpff_pkg::*;
(
    input  wire logic        sys_clk,  // System clock, 10 MHz
    input  wire logic        srst,     // Synchronous reset, active high
    input  wire gpff_pins_t  pins,     // Asynchronous pin inputs
    output gpff_state_t      one_o,    // One outputs of all elements
    output gpff_state_t      zero_o    // Zero outputs of all elements
);

    gpff_pins_t  sync1_q;    // First synchroniser stage
    gpff_pins_t  sync2_q;    // Second stage
    gpff_pins_t  sync3_q;    // Third stage
    gpff_pins_t  filt_q;     // Accepted pin levels
    gpff_pins_t  prev_q;     // Accepted levels one cycle earlier
    logic        rs_q;       // Unclocked latch state
    logic        rs_both_q;  // Both unclocked inputs held low
    logic        cl_q;       // Clocked latch state
    logic        d_q;        // Data flip-flop state
    logic        master_q;   // J-K master stage
    logic        slave_q;    // J-K slave stage
    logic        d_rise;
    logic        jk_rise;
    logic        jk_fall;
    logic        d_int_set;
    logic        d_int_reset;
    logic        jk_direct;
    logic        master_d;

    // Three-stage chain; a level is accepted only once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_q <= GPFF_PINS_IDLE;
            sync2_q <= GPFF_PINS_IDLE;
            sync3_q <= GPFF_PINS_IDLE;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < GPFF_NPINS; gi++) begin : g_filt
            // Per-bit agreement filter
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    filt_q[gi] <= GPFF_PINS_IDLE[gi];
                end else if (sync2_q[gi] == sync3_q[gi]) begin
                    filt_q[gi] <= sync3_q[gi];
                end
            end
        end
    endgenerate

    // Edge history of accepted levels
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_q <= GPFF_PINS_IDLE;
        end else begin
            prev_q <= filt_q;
        end
    end

    // Sampled transitions replace the real clock edges
    assign d_rise  = filt_q.d_clk && !prev_q.d_clk;
    assign jk_rise = filt_q.jk_clk && !prev_q.jk_clk;
    assign jk_fall = !filt_q.jk_clk && prev_q.jk_clk;

    // Unclocked latch; the input still low after the other is released wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rs_q      <= GPFF_BIT_RST;
            rs_both_q <= GPFF_BIT_RST;
        end else begin
            rs_both_q <= !filt_q.rs_set_n && !filt_q.rs_reset_n;
            if (!filt_q.rs_set_n && filt_q.rs_reset_n) begin
                rs_q <= 1'b1;
            end else if (filt_q.rs_set_n && !filt_q.rs_reset_n) begin
                rs_q <= 1'b0;
            end
        end
    end

    // Clocked latch; both high is the driver's fault, so the state simply holds
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cl_q <= GPFF_BIT_RST;
        end else if (filt_q.cl_clk) begin
            if (filt_q.cl_set && !filt_q.cl_reset) begin
                cl_q <= 1'b1;
            end else if (filt_q.cl_reset && !filt_q.cl_set) begin
                cl_q <= 1'b0;
            end
        end
    end

    // Set path from data, reset path from its inverse
    assign d_int_set   = filt_q.d_data;
    assign d_int_reset = !filt_q.d_data;

    // Data flip-flop; direct inputs override the clock, set taking priority
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            d_q <= GPFF_BIT_RST;
        end else if (!filt_q.d_set_n) begin
            d_q <= 1'b1;
        end else if (!filt_q.d_reset_n) begin
            d_q <= 1'b0;
        end else if (d_rise) begin  // Only sampled at the edge, so data is locked out
            if (d_int_set) begin
                d_q <= 1'b1;
            end else if (d_int_reset) begin
                d_q <= 1'b0;
            end
        end
    end

    assign jk_direct = !filt_q.jk_set_n || !filt_q.jk_reset_n;

    // Master steering from J, K and the present slave state
    always_comb begin
        master_d = master_q;
        unique case ({filt_q.jk_j, filt_q.jk_k})
            2'b00: master_d = slave_q;
            2'b10: master_d = 1'b1;
            2'b01: master_d = 1'b0;
            2'b11: master_d = !slave_q;
        endcase
    end

    // J-K master-slave; a direct input forces both stages so they stay consistent
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            master_q <= GPFF_BIT_RST;
            slave_q  <= GPFF_BIT_RST;
        end else if (!filt_q.jk_set_n) begin
            master_q <= 1'b1;
            slave_q  <= 1'b1;
        end else if (!filt_q.jk_reset_n) begin
            master_q <= 1'b0;
            slave_q  <= 1'b0;
        end else if (jk_rise) begin
            master_q <= master_d;  // Slave left alone while high
        end else if (jk_fall) begin
            slave_q <= master_q;
        end
    end

    // Both unclocked outputs read high while both inputs are held low
    assign one_o  = '{rs_one: rs_q || rs_both_q, cl_one: cl_q, d_one: d_q, jk_one: slave_q};
    assign zero_o = '{rs_one: !rs_q || rs_both_q, cl_one: !cl_q, d_one: !d_q, jk_one: !slave_q};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_rs_set_wins: assert property (!filt_q.rs_set_n && filt_q.rs_reset_n |=> rs_q && one_o.rs_one)
        else $error("latch set not taken");
    a_cl_low_hold: assert property (!filt_q.cl_clk |=> $stable(cl_q))
        else $error("clocked latch moved with clock low");
    a_d_edge_load: assert property (d_rise && filt_q.d_set_n && filt_q.d_reset_n |=> d_q == $past(filt_q.d_data))
        else $error("data not loaded at rising edge");
    a_d_lockout: assert property (filt_q.d_clk && !d_rise && filt_q.d_set_n && filt_q.d_reset_n |=> $stable(d_q))
        else $error("data flip-flop changed during lockout");
    a_d_direct: assert property (!filt_q.d_reset_n && filt_q.d_set_n |=> !d_q ##1 (!d_q || !filt_q.d_reset_n || d_rise || !filt_q.d_set_n))
        else $error("direct reset ignored");
    a_jk_high_stable: assert property (filt_q.jk_clk && !jk_direct |=> $stable(slave_q))
        else $error("slave changed with clock high");
    a_jk_master_load: assert property (jk_rise && !jk_direct && filt_q.jk_j && filt_q.jk_k |=> master_q == !slave_q)
        else $error("master not complemented");
    a_jk_fall_copy: assert property (jk_fall && !jk_direct |=> slave_q == $past(master_q))
        else $error("slave not copied at falling edge");
    a_jk_keep: assert property (jk_rise && !jk_direct && !filt_q.jk_j && !filt_q.jk_k |=> master_q == slave_q)
        else $error("idle inputs changed master");
    a_jk_only_j: assert property (jk_rise && !jk_direct && filt_q.jk_j && !filt_q.jk_k |=> master_q)
        else $error("only J did not give one");
    // Only K must clear the master, mirror of the J-only case
    a_jk_only_k: assert property (jk_rise && !jk_direct && !filt_q.jk_j && filt_q.jk_k |=> !master_q)
        else $error("only K did not give zero");
    // Direct set wins over clock and over direct reset
    a_d_set: assert property (!filt_q.d_set_n |=> d_q)
        else $error("direct set ignored");
    // Reset input alone must clear the unclocked latch
    a_rs_reset_wins: assert property (filt_q.rs_set_n && !filt_q.rs_reset_n |=> !rs_q && one_o.rs_one == 1'b0)
        else $error("latch reset not taken");

    c_d_load: cover property (d_rise && filt_q.d_data ##1 d_q);
    c_jk_toggle: cover property (jk_rise && filt_q.jk_j && filt_q.jk_k ##[1:20] jk_fall);
    c_rs_both_low: cover property (rs_both_q ##1 !rs_both_q);
    c_cl_set: cover property (filt_q.cl_clk && filt_q.cl_set ##1 cl_q);
    // Direct reset on the J-K pair while its clock is idle
    c_jk_direct: cover property (!filt_q.jk_reset_n && !filt_q.jk_clk ##1 !slave_q);

endmodule

/* File: bench/gpff_drv.sv */
// Partner model: surrounding synchronous logic that drives the flip-flop pins
module gpff_drv
    import gpff_pkg::*;
(
    input  wire logic  sys_clk,  // System clock
    output gpff_pins_t pins      // Pin levels toward the block
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels: clocks low, active-low inputs high
    initial pins = GPFF_PINS_IDLE;

    // Change on the falling edge, then hold long enough for the input filter
    task automatic drive(input gpff_pins_t v);
        gpff_pins_t w;
        w = v;
        // Never request set and reset together inside a latch pulse
        if (v.cl_clk && v.cl_set && v.cl_reset) begin
            w.cl_reset = 1'h0;
        end
        @(negedge sys_clk);
        pins = w;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
endmodule

/* File: bench/general_purpose_flip_flops_bench.sv */
// Self-checking bench for the general-purpose flip-flop block
module general_purpose_flip_flops_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import gpff_pkg::*;

    logic        sys_clk = 1'h0;
    logic        srst    = 1'h1;
    gpff_pins_t  pins;
    gpff_pins_t  p;
    gpff_state_t one_o;
    gpff_state_t zero_o;
    int          failures  = 0;
    int          cmp_count = 0;
    int          cycles    = 0;

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    gpff_drv i_drv (.sys_clk(sys_clk), .pins(pins));
    gpff_top i_dut (.sys_clk(sys_clk), .srst(srst), .pins(pins), .one_o(one_o), .zero_o(zero_o));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %b want %b", $time, seen, exp);
        end
    endtask

    // Hang guard, far above the roughly 330 cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end

    // Overlapping lows: the input released last decides
    task automatic t_rs();
        p.rs_set_n = 1'h0; i_drv.drive(p); chk(one_o.rs_one, 1'h1);
        p.rs_reset_n = 1'h0; i_drv.drive(p); chk(zero_o.rs_one, 1'h1);
        p.rs_reset_n = 1'h1; i_drv.drive(p);
        p.rs_set_n = 1'h1; i_drv.drive(p); chk(one_o.rs_one, 1'h1);
        p.rs_reset_n = 1'h0; i_drv.drive(p);
        p.rs_set_n = 1'h0; i_drv.drive(p);
        p.rs_set_n = 1'h1; i_drv.drive(p);
        p.rs_reset_n = 1'h1; i_drv.drive(p); chk(one_o.rs_one, 1'h0);
    endtask

    // Clocked latch moves only inside a pulse
    task automatic t_cl();
        p.cl_set = 1'h1; i_drv.drive(p); chk(one_o.cl_one, 1'h0);
        p.cl_clk = 1'h1; i_drv.drive(p); chk(one_o.cl_one, 1'h1);
        p.cl_clk = 1'h0; i_drv.drive(p);
        p.cl_set = 1'h0; i_drv.drive(p);
        p.cl_reset = 1'h1; i_drv.drive(p); chk(one_o.cl_one, 1'h1);
        p.cl_clk = 1'h1; i_drv.drive(p); chk(one_o.cl_one, 1'h0);
        p.cl_clk = 1'h0; i_drv.drive(p);
        p.cl_reset = 1'h0; i_drv.drive(p); chk(zero_o.cl_one, 1'h1);
    endtask

    // Leading-edge load, lockout while high, direct inputs
    task automatic t_d();
        p.d_data = 1'h1; i_drv.drive(p);
        p.d_clk = 1'h1; i_drv.drive(p); chk(one_o.d_one, 1'h1);
        chk(zero_o.d_one, 1'h0);
        p.d_data = 1'h0; i_drv.drive(p); chk(one_o.d_one, 1'h1);
        p.d_clk = 1'h0; i_drv.drive(p); chk(one_o.d_one, 1'h1);
        p.d_clk = 1'h1; i_drv.drive(p); chk(one_o.d_one, 1'h0);
        p.d_set_n = 1'h0; i_drv.drive(p); chk(one_o.d_one, 1'h1);
        p.d_set_n = 1'h1; i_drv.drive(p); chk(one_o.d_one, 1'h1);
        p.d_reset_n = 1'h0; i_drv.drive(p); chk(zero_o.d_one, 1'h1);
        p.d_reset_n = 1'h1; i_drv.drive(p);
        p.d_clk = 1'h0; i_drv.drive(p); chk(one_o.d_one, 1'h0);
    endtask

    // One J-K pulse: outputs frozen while high, settle after the fall
    task automatic jk_pulse(input logic j, input logic k, input logic prev, input logic exp);
        p.jk_j = j;
        p.jk_k = k;
        i_drv.drive(p);
        p.jk_clk = 1'h1; i_drv.drive(p); chk(one_o.jk_one, prev);
        p.jk_clk = 1'h0; i_drv.drive(p); chk(one_o.jk_one, exp);
        chk(zero_o.jk_one, ~exp);
    endtask

    task automatic t_jk();
        jk_pulse(1'h1, 1'h1, 1'h0, 1'h1);
        jk_pulse(1'h0, 1'h0, 1'h1, 1'h1);
        jk_pulse(1'h0, 1'h1, 1'h1, 1'h0);
        jk_pulse(1'h1, 1'h0, 1'h0, 1'h1);
        jk_pulse(1'h1, 1'h1, 1'h1, 1'h0);
        p.jk_set_n = 1'h0; i_drv.drive(p); chk(one_o.jk_one, 1'h1);
        p.jk_set_n = 1'h1; i_drv.drive(p);
        p.jk_reset_n = 1'h0; i_drv.drive(p); chk(one_o.jk_one, 1'h0);
        p.jk_reset_n = 1'h1; i_drv.drive(p);
    endtask

    // Reset, then every scenario in turn
    initial begin
        p = GPFF_PINS_IDLE;
        repeat (8) @(negedge sys_clk);
        srst = 1'h0;
        @(negedge sys_clk);
        chk(one_o === GPFF_STATE_RST, 1'h1);
        chk(zero_o === ~GPFF_STATE_RST, 1'h1);
        t_rs();
        t_cl();
        t_d();
        t_jk();
        summarize();
    end
endmodule
